/* File: core/bit_exec_pkg.sv */
package bit_exec_pkg;
  // Instruction field layout
  localparam int unsigned OP_LOW_NIB_LSB = 0;
  localparam int unsigned OP_LOW_NIB_MSB = 3;
  localparam int unsigned OP_IDX_LSB = 4;
  localparam int unsigned OP_IDX4_MSB = 7;
  localparam int unsigned OP_IDX3_MSB = 6;
  localparam int unsigned OP_VAL_BIT = 7;
  localparam int unsigned OP_MID_LSB = 8;
  localparam int unsigned OP_MID_MSB = 11;
  localparam int unsigned OP_HI_LSB = 12;
  localparam int unsigned OP_HI_MSB = 15;
  localparam int unsigned OP_SRCW_BIT = 15;
  localparam int unsigned OP_DST_LSB = 8;
  localparam int unsigned OP_DST_MSB = 14;
  localparam int unsigned OP_MOD_LSB = 8;
  localparam int unsigned OP_MOD_MSB = 11;
  localparam int unsigned OP_BSRC_LSB = 12;
  localparam int unsigned OP_BSRC_MSB = 14;

  // Nibble codes
  localparam logic [3:0] NIB_ACC_CLASS = 4'hA;
  localparam logic [3:0] NIB_BIT_CLASS = 4'h7;
  localparam logic [3:0] HI_C_TO_ACC = 4'hF;
  localparam logic [3:0] HI_ACC_TO_C = 4'hE;
  localparam logic [3:0] HI_NEGATE = 4'h8;
  localparam logic [3:0] HI_OR_LOW3 = 4'h2;
  localparam logic [15:0] OPC_CLR_C = 16'hDA0A;
  localparam logic [15:0] OPC_SET_C = 16'hDA1A;
  localparam logic [15:0] OPC_NEGATE = 16'h8A1A;

  // Module codes for bit set and clear
  localparam logic [3:0] MOD_SYSTEM = 4'h8;
  localparam logic [3:0] MOD_PERIPH_MAX = 4'h5;
  localparam logic [6:0] DST_STATUS = 7'h48;

  // Status flag positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_S = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_E = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Operation class
  typedef enum {
    OP_NONE,
    OP_C_TO_ACC,
    OP_ACC_TO_C,
    OP_SRC_TO_C,
    OP_CLR_C,
    OP_SET_C,
    OP_BIT_WR,
    OP_NEGATE,
    OP_OR
  } op_type;

  // Register-module write request
  typedef struct packed {
    logic en;
    logic [6:0] dst;
    logic [7:0] data;
  } reg_write_type;
endpackage

/* File: core/carry_bit_negate_or_exec.sv */
`timescale 1ns/1ps
// What this block does
// - Carry-to-accumulator-bit opcode copies carry into the indexed accumulator bit.
// - After that write, sign follows accumulator top bit, zero follows all-zero.
// - Accumulator-bit-to-carry opcode loads carry from the indexed accumulator bit.
// - Source-bit-to-carry opcode loads carry from indexed bit of the named source.
// - Fixed clear-carry opcode forces carry to zero, other flags unchanged, prefix consumed.
// - Fixed set-carry opcode forces carry to one, other flags unchanged, prefix consumed.
// - Bit-clear opcode clears the indexed destination bit, others preserved.
// - Bit-set opcode sets the indexed destination bit, others preserved.
// - Bit writes to the status register change carry and equal accordingly.
// - Bit set and clear only serve system module 8 and modules 0 to 5.
// - Negate replaces accumulator with its two's complement, updates sign and zero.
// - OR merges source into the accumulator and updates sign and zero.
// - For 8-bit OR sources, prefix register supplies the upper byte when loaded.
// - 8-bit into 16-bit zeroes the upper byte unless the prefix supplies it.
module carry_bit_negate_or_exec
  import bit_exec_pkg::*;
#(
  parameter int unsigned ACC_W = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Instruction path
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  // Source operand read from the register modules
  input wire logic [15:0] src_data,
  input wire logic src_is_byte,
  // Prefix load
  input wire logic prefix_load,
  input wire logic [7:0] prefix_data,
  // Destination current value for bit writes
  input wire logic [7:0] dst_data,
  // Accumulator load from the rest of the core
  input wire logic acc_load,
  input wire logic [ACC_W-1:0] acc_load_data,
  // Datapath state
  output logic [ACC_W-1:0] pointer_selected_accumulator,
  output logic [7:0] processor_status_flag_register,
  output reg_write_type reg_write,
  output logic prefix_valid
);
  op_type op;
  logic [7:0] prefix_register;

  op_decode u_dec (
    .instr(instr),
    .instr_valid(instr_valid),
    .op(op)
  );

  // Fields
  wire [3:0] idx4 = instr[OP_IDX4_MSB:OP_IDX_LSB];
  wire [2:0] idx3 = instr[OP_IDX3_MSB:OP_IDX_LSB];
  wire [2:0] bsrc_idx = instr[OP_BSRC_MSB:OP_BSRC_LSB];
  wire bit_val = instr[OP_VAL_BIT];
  wire [6:0] dst_code = instr[OP_DST_MSB:OP_DST_LSB];
  wire carry = processor_status_flag_register[FLAG_C];
  wire [ACC_W-1:0] acc = pointer_selected_accumulator;

  // Carry into accumulator bit
  logic [ACC_W-1:0] acc_with_c;
  always_comb begin
    acc_with_c = acc;
    acc_with_c[idx4] = carry;
  end

  // Operand; byte sources take the upper byte from prefix or zero
  wire [7:0] src_hi = src_is_byte ? (prefix_valid ? prefix_register : ZERO_BYTE)
                                  : src_data[15:8];
  wire [15:0] operand = {src_hi, src_data[7:0]};

  // Results
  wire [ACC_W-1:0] acc_negated = ACC_W'(~acc + ACC_W'(1));
  wire [ACC_W-1:0] acc_or = acc | ACC_W'(operand);

  // Bit write data; status writes start from the live flags, not the module copy
  wire dst_is_status = (dst_code == DST_STATUS);
  wire [7:0] bit_wr_base = dst_is_status ? processor_status_flag_register : dst_data;
  logic [7:0] bit_wr_data;
  always_comb begin
    bit_wr_data = bit_wr_base;
    bit_wr_data[idx3] = bit_val;
  end

  // Accumulator next value
  logic [ACC_W-1:0] next_acc;
  logic acc_touched;
  always_comb begin
    next_acc = acc;
    acc_touched = 1'b1;
    case (op)
      OP_C_TO_ACC: next_acc = acc_with_c;
      OP_NEGATE: next_acc = acc_negated;
      OP_OR: next_acc = acc_or;
      default: begin
        acc_touched = 1'b0;
        next_acc = acc_load ? acc_load_data : acc;
      end
    endcase
  end

  // Status next value
  logic [7:0] next_status;
  always_comb begin
    next_status = processor_status_flag_register;
    case (op)
      OP_ACC_TO_C: next_status[FLAG_C] = acc[idx4];
      OP_SRC_TO_C: next_status[FLAG_C] = src_data[bsrc_idx];
      OP_CLR_C: next_status[FLAG_C] = 1'b0;
      OP_SET_C: next_status[FLAG_C] = 1'b1;
      OP_BIT_WR: begin
        if (dst_is_status) begin
          next_status[FLAG_C] = bit_wr_data[FLAG_C];
          next_status[FLAG_E] = bit_wr_data[FLAG_E];
        end
      end
      default: next_status = processor_status_flag_register;
    endcase
    if (acc_touched) begin
      next_status[FLAG_S] = next_acc[ACC_W-1];
      next_status[FLAG_Z] = (next_acc == '0);
    end
  end

  // Register-module write, only for supported modules
  reg_write_type next_wr;
  always_comb begin
    next_wr.en = (op == OP_BIT_WR) && !dst_is_status;
    next_wr.dst = dst_code;
    next_wr.data = bit_wr_data;
  end

  // Prefix consumed by any valid instruction without a prefix load, whether or not it uses it
  wire prefix_used = instr_valid && !prefix_load;

  // Single-cycle state update
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pointer_selected_accumulator <= '0;
      processor_status_flag_register <= STATUS_RESET;
      reg_write <= '0;
    end else begin
      pointer_selected_accumulator <= next_acc;
      processor_status_flag_register <= next_status;
      reg_write <= next_wr;
    end
  end

  // Prefix holding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prefix_register <= ZERO_BYTE;
      prefix_valid <= 1'b0;
    end else if (prefix_load) begin
      prefix_register <= prefix_data;
      prefix_valid <= 1'b1;
    end else if (prefix_used) begin
      prefix_valid <= 1'b0;
    end
  end

  chk_negate_result: assert property (@(posedge clk) disable iff (!nrst)
    op == OP_NEGATE |=> pointer_selected_accumulator == ACC_W'(~$past(acc) + ACC_W'(1)))
    else $error("negate result wrong");
  chk_clear_carry: assert property (@(posedge clk) disable iff (!nrst)
    op == OP_CLR_C |=> !processor_status_flag_register[FLAG_C]
      && $stable(pointer_selected_accumulator))
    else $error("carry not cleared");
  chk_set_carry: assert property (@(posedge clk) disable iff (!nrst)
    op == OP_SET_C |=> processor_status_flag_register[FLAG_C])
    else $error("carry not set");
  chk_acc_bit_carry: assert property (@(posedge clk) disable iff (!nrst)
    op == OP_ACC_TO_C |=> processor_status_flag_register[FLAG_C] == $past(acc[idx4]))
    else $error("carry not loaded from accumulator bit");
  chk_src_bit_carry: assert property (@(posedge clk) disable iff (!nrst)
    op == OP_SRC_TO_C |=>
      processor_status_flag_register[FLAG_C] == $past(src_data[bsrc_idx]))
    else $error("carry not loaded from source bit");
  chk_carry_to_bit: assert property (@(posedge clk) disable iff (!nrst)
    op == OP_C_TO_ACC |=> pointer_selected_accumulator[$past(idx4)] == $past(carry))
    else $error("carry not copied to accumulator");
  chk_sign_zero: assert property (@(posedge clk) disable iff (!nrst)
    (op == OP_OR || op == OP_NEGATE || op == OP_C_TO_ACC) |=>
      processor_status_flag_register[FLAG_Z] == (pointer_selected_accumulator == '0)
      && processor_status_flag_register[FLAG_S] == pointer_selected_accumulator[ACC_W-1])
    else $error("sign or zero flag wrong");
  chk_or_result: assert property (@(posedge clk) disable iff (!nrst)
    op == OP_OR |=> pointer_selected_accumulator == ($past(acc) | ACC_W'($past(operand))))
    else $error("or result wrong");
  chk_prefix_upper: assert property (@(posedge clk) disable iff (!nrst)
    (op == OP_OR && src_is_byte && prefix_valid) |=> pointer_selected_accumulator ==
      ($past(acc) | ACC_W'({$past(prefix_register), $past(src_data[7:0])})))
    else $error("prefix byte not used as upper byte");
  chk_byte_zero_upper: assert property (@(posedge clk) disable iff (!nrst)
    (op == OP_OR && src_is_byte && !prefix_valid) |=> pointer_selected_accumulator ==
      ($past(acc) | ACC_W'($past(src_data[7:0]))))
    else $error("byte source upper byte not zero");
  chk_bit_write: assert property (@(posedge clk) disable iff (!nrst)
    (op == OP_BIT_WR && !dst_is_status) |=>
      reg_write.en && reg_write.data[$past(idx3)] == $past(bit_val))
    else $error("bit write wrong");
  chk_bit_keep: assert property (@(posedge clk) disable iff (!nrst)
    (op == OP_BIT_WR && !dst_is_status) |=> reg_write.dst == $past(dst_code)
      && ((reg_write.data ^ $past(dst_data)) & ~(8'h01 << $past(idx3))) == 8'h00)
    else $error("bit write disturbed other bits");
  chk_status_keep: assert property (@(posedge clk) disable iff (!nrst)
    (op == OP_BIT_WR && dst_is_status && idx3 != FLAG_C) |=> !reg_write.en
      && $stable(processor_status_flag_register[FLAG_C]))
    else $error("status bit write disturbed carry");
  chk_status_equal: assert property (@(posedge clk) disable iff (!nrst)
    (op == OP_BIT_WR && dst_is_status && idx3 == FLAG_E) |=>
      processor_status_flag_register[FLAG_E] == $past(bit_val))
    else $error("status bit write missed equal flag");
  chk_refused_module: assert property (@(posedge clk) disable iff (!nrst)
    (instr_valid && instr[OP_SRCW_BIT]
      && instr[OP_LOW_NIB_MSB:OP_LOW_NIB_LSB] == NIB_BIT_CLASS
      && instr[OP_MOD_MSB:OP_MOD_LSB] > MOD_PERIPH_MAX
      && instr[OP_MOD_MSB:OP_MOD_LSB] != MOD_SYSTEM) |=> !reg_write.en)
    else $error("unsupported module written");
  chk_prefix_drop: assert property (@(posedge clk) disable iff (!nrst)
    (instr_valid && !prefix_load) |=> !prefix_valid)
    else $error("prefix not consumed");
endmodule

/* File: core/op_decode.sv */
`timescale 1ns/1ps
module op_decode
  import bit_exec_pkg::*;
(
  // Instruction word
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  // Decoded class
  output op_type op
);
  // Field views
  wire [3:0] low_nib = instr[OP_LOW_NIB_MSB:OP_LOW_NIB_LSB];
  wire [3:0] mid_nib = instr[OP_MID_MSB:OP_MID_LSB];
  wire [3:0] hi_nib = instr[OP_HI_MSB:OP_HI_LSB];
  wire [3:0] mod_code = instr[OP_MOD_MSB:OP_MOD_LSB];
  wire acc_class = (mid_nib == NIB_ACC_CLASS) && (low_nib == NIB_ACC_CLASS);
  wire bit_class = (low_nib == NIB_BIT_CLASS);
  wire dst_form = instr[OP_SRCW_BIT];
  wire mod_ok = (mod_code == MOD_SYSTEM) || (mod_code <= MOD_PERIPH_MAX);
  wire or_form = (instr[OP_HI_MSB-1:OP_HI_LSB] == HI_OR_LOW3[2:0]) &&
                 (mid_nib == NIB_ACC_CLASS);

  // Priority decode: fixed words first, then classes
  always_comb begin
    op = OP_NONE;
    if (!instr_valid) begin
      op = OP_NONE;
    end else if (instr == OPC_CLR_C) begin
      op = OP_CLR_C;
    end else if (instr == OPC_SET_C) begin
      op = OP_SET_C;
    end else if (instr == OPC_NEGATE) begin
      op = OP_NEGATE;
    end else if (acc_class && hi_nib == HI_C_TO_ACC) begin
      op = OP_C_TO_ACC;
    end else if (acc_class && hi_nib == HI_ACC_TO_C) begin
      op = OP_ACC_TO_C;
    end else if (bit_class && dst_form && mod_ok) begin
      op = OP_BIT_WR;
    end else if (mid_nib == NIB_BIT_CLASS) begin
      op = OP_SRC_TO_C;
    end else if (or_form) begin
      op = OP_OR;
    end else begin
      op = OP_NONE;
    end
  end
endmodule

/* File: testbench/carry_bit_negate_or_exec_bench.sv */
`timescale 1ns/1ps
module carry_bit_negate_or_exec_bench import bit_exec_pkg::*; ;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  logic [15:0] src_data = 16'h0000;
  logic src_is_byte = 1'b0;
  logic prefix_load = 1'b0;
  logic [7:0] prefix_data = 8'h00;
  logic acc_load = 1'b0;
  logic [15:0] acc_load_data = 16'h0000;
  logic [7:0] dst_data;
  logic [15:0] acc;
  logic [7:0] status;
  reg_write_type reg_write;
  logic prefix_valid;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  // Block and register modules
  carry_bit_negate_or_exec #(.ACC_W(16)) i_dut (
    .clk(clk), .nrst(nrst), .instr(instr), .instr_valid(instr_valid),
    .src_data(src_data), .src_is_byte(src_is_byte), .prefix_load(prefix_load),
    .prefix_data(prefix_data), .dst_data(dst_data), .acc_load(acc_load),
    .acc_load_data(acc_load_data), .pointer_selected_accumulator(acc),
    .processor_status_flag_register(status), .reg_write(reg_write),
    .prefix_valid(prefix_valid));
  reg_module_model i_regs (.clk(clk), .instr(instr), .reg_write(reg_write),
    .dst_data(dst_data));
  // Clock
  always #5 clk = ~clk;
  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end
  // Word compare
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Flag compare
  task automatic check_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One instruction, result settled on return
  task automatic exec(input logic [15:0] i, input logic [15:0] s, input logic b);
    @(posedge clk);
    instr <= i;
    instr_valid <= 1'b1;
    src_data <= s;
    src_is_byte <= b;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  // Accumulator load from the core
  task automatic load_acc(input logic [15:0] v);
    @(posedge clk);
    acc_load <= 1'b1;
    acc_load_data <= v;
    @(posedge clk);
    acc_load <= 1'b0;
    #1;
  endtask
  // Prefix byte load
  task automatic load_pfx(input logic [7:0] v);
    @(posedge clk);
    prefix_load <= 1'b1;
    prefix_data <= v;
    @(posedge clk);
    prefix_load <= 1'b0;
    #1;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check(acc, 16'h0000);
    check({status, 7'h00, prefix_valid}, 16'h0000);
    exec(OPC_SET_C, 16'h0000, 1'b0);
    check_flag(status[FLAG_C], 1'b1);
    load_acc(16'h8000);
    exec(OPC_CLR_C, 16'h0000, 1'b0);
    check_flag(status[FLAG_C], 1'b0);
    check(acc, 16'h8000);
    exec(16'hFAFA, 16'h0000, 1'b0);
    check(acc, 16'h0000);
    check({status[FLAG_S], status[FLAG_Z]}, 2'b01);
    exec(OPC_SET_C, 16'h0000, 1'b0);
    exec(16'hFA0A, 16'h0000, 1'b0);
    check(acc, 16'h0001);
    check_flag(status[FLAG_Z], 1'b0);
    exec(16'hFAFA, 16'h0000, 1'b0);
    check(acc, 16'h8001);
    check_flag(status[FLAG_S], 1'b1);
    load_acc(16'h01C0);
    exec(OPC_CLR_C, 16'h0000, 1'b0);
    exec(16'hEA8A, 16'h0000, 1'b0);
    check_flag(status[FLAG_C], 1'b1);
    check(acc, 16'h01C0);
    exec(16'hEA0A, 16'h0000, 1'b0);
    check_flag(status[FLAG_C], 1'b0);
    exec(16'h1710, 16'h00FE, 1'b0);
    check_flag(status[FLAG_C], 1'b1);
    exec(16'h0710, 16'h00FE, 1'b0);
    check_flag(status[FLAG_C], 1'b0);
    exec(16'h8017, 16'h0000, 1'b0);
    check(reg_write, 16'h80FC);
    exec(16'h8077, 16'h0000, 1'b0);
    check(reg_write, 16'h807C);
    exec(16'h8097, 16'h0000, 1'b0);
    check(reg_write, 16'h807E);
    exec(16'h8587, 16'h0000, 1'b0);
    check(reg_write, 16'h85FF);
    exec(16'h8887, 16'h0000, 1'b0);
    check(reg_write, 16'h88FF);
    exec(16'h8697, 16'h0000, 1'b0);
    check_flag(reg_write.en, 1'b0);
    exec(16'hC887, 16'h0000, 1'b0);
    check_flag(status[FLAG_C], 1'b1);
    exec(16'hC8B7, 16'h0000, 1'b0);
    check_flag(status[FLAG_E], 1'b1);
    check_flag(status[FLAG_C], 1'b1);
    exec(16'hC807, 16'h0000, 1'b0);
    check({status[FLAG_E], status[FLAG_C], reg_write.en}, 3'b100);
    load_acc(16'hFEED);
    exec(OPC_NEGATE, 16'h0000, 1'b0);
    check(acc, 16'h0113);
    check({status[FLAG_S], status[FLAG_Z]}, 2'b00);
    exec(OPC_NEGATE, 16'h0000, 1'b0);
    check({status[FLAG_S], status[FLAG_Z]}, 2'b10);
    load_acc(16'h0000);
    exec(OPC_NEGATE, 16'h0000, 1'b0);
    check({acc[1:0], status[FLAG_Z]}, 3'b001);
    load_acc(16'h2345);
    // Source is A[0], never the active accumulator
    exec(16'hAA09, 16'h0F0F, 1'b0);
    check(acc, 16'h2F4F);
    load_acc(16'h2345);
    load_pfx(8'h11);
    check_flag(prefix_valid, 1'b1);
    exec(16'h2A10, 16'hFF33, 1'b1);
    check(acc, 16'h3377);
    check_flag(prefix_valid, 1'b0);
    load_pfx(8'h44);
    exec(OPC_SET_C, 16'h0000, 1'b0);
    check_flag(prefix_valid, 1'b0);
    exec(16'h2A10, 16'hFF80, 1'b1);
    check(acc, 16'h33F7);
    complete_run();
  end
endmodule

/* File: testbench/reg_module_model.sv */
`timescale 1ns/1ps
module reg_module_model
  import bit_exec_pkg::*;
(
  // Clock and instruction view
  input wire logic clk,
  input wire logic [15:0] instr,
  // Write request from the block
  input wire reg_write_type reg_write,
  // Current destination value
  output logic [7:0] dst_data
);
  logic [7:0] mem [0:127];
  // Destination read follows the bit-write destination field
  assign dst_data = mem[instr[OP_DST_MSB:OP_DST_LSB]];
  // Every register starts at FE
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'hFE;
    end
  end
  // Whole-byte write from the block
  always @(posedge clk) begin
    if (reg_write.en === 1'b1) begin
      mem[reg_write.dst] <= reg_write.data;
    end
  end
endmodule
